// ### common/dac_cfg_consts.vh
// constants for the converter configuration register bank
`ifndef DAC_CFG_CONSTS_VH
`define DAC_CFG_CONSTS_VH

// ============================================================
// register offsets
`define ADDR_PORT_POWER      5'h00
`define ADDR_FILTER_MOD      5'h01
`define ADDR_INPUT_FORMAT    5'h02
`define ADDR_CLKOUT_PRESCALE 5'h03
`define ADDR_PLL_CONTROL     5'h04
`define ADDR_I_FINE_GAIN     5'h05
`define ADDR_I_COARSE_GAIN   5'h06
`define ADDR_I_OFFSET_HIGH   5'h07
`define ADDR_I_OFFSET_LOW    5'h08
`define ADDR_Q_FINE_GAIN     5'h09
`define ADDR_Q_COARSE_GAIN   5'h0a
`define ADDR_Q_OFFSET_HIGH   5'h0b
`define ADDR_Q_OFFSET_LOW    5'h0c

// ============================================================
// reset values
`define RST_PORT_POWER       8'h00
`define RST_FILTER_MOD       8'h04
`define RST_INPUT_FORMAT     8'h00
`define RST_CLKOUT_PRESCALE  8'h00
`define RST_PLL_CONTROL      8'h00
`define RST_GAIN_OFFSET      8'h00

// ============================================================
// writable bit masks (undefined bits are dropped)
`define MASK_PORT_POWER      8'hdc
`define MASK_FILTER_MOD      8'hff
`define MASK_INPUT_FORMAT    8'hf7
`define MASK_CLKOUT_PRESCALE 8'h83
`define MASK_PLL_CONTROL     8'hc7
`define MASK_FULL            8'hff
`define MASK_COARSE_GAIN     8'h0f
`define MASK_OFFSET_LOW      8'h83

// ============================================================
// field positions
`define BIT_SDIO_BIDIR       7
`define BIT_LSB_FIRST        6
`define BIT_SOFT_RESET       5
`define BIT_SLEEP            4
`define BIT_POWER_DOWN       3
`define BIT_ONE_RESISTOR     2
`define BIT_PLL_LOCK         1
`define BIT_ZERO_STUFF       3
`define BIT_REAL_MIX         2
`define BIT_POS_ROTATION     1
`define BIT_PIN8_RATE_CLK    0
`define BIT_STRAIGHT_BINARY  7
`define BIT_ONE_PORT         6
`define BIT_DRIVER_STRENGTH  5
`define BIT_RATE_CLK_INVERT  4
`define BIT_WORDCLK_INVERT   2
`define BIT_CHSEL_INVERT     1
`define BIT_Q_FIRST          0
`define BIT_CLK_ON_SDO       7
`define BIT_PLL_ENABLE       7
`define BIT_CP_MANUAL        6
`define BIT_OFFSET_TO_COMP   7

// ============================================================
// instruction byte fields
`define INSTR_READ_BIT       7
`define INSTR_COUNT_HI       6
`define INSTR_COUNT_LO       5

`endif

// ### rtl/pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module pin_sync
#(
	parameter INIT = 1'b0
)
(
	input  wire i_clock,
	input  wire i_rst_n,
	input  wire i_pin,
	output reg  o_level
);

	reg stage1_r;
	reg stage2_r;
	reg stage3_r;

	// stage1 only feeds stage2; a change counts once stages 2 and 3 agree
	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stage1_r <= INIT;
			stage2_r <= INIT;
			stage3_r <= INIT;
			o_level  <= INIT;
		end
		else
		begin
			stage1_r <= i_pin;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			if (stage2_r == stage3_r)
				o_level <= stage3_r;
		end
	end

endmodule // pin_sync

// ### rtl/dac_config_register_bank.v
// configuration register bank behind the serial control port
`timescale 1ns/1ps
`include "dac_cfg_consts.vh"

// How it works
// - 00h bit7 lets read data drive the data I/O pin; bit6 selects LSB-first
// - writing one to 00h bit5 resets registers and restarts; reads as zero
// - soft reset keeps 00h; hardware reset pin high returns every register to its reset value
// - 00h bit4 sleeps both output currents; bit3 powers down all but serial port
// - 00h bit2 set shares one reference resistor and halves full-scale current
// - 00h bit1 reads PLL lock while the PLL is enabled
// - 01h bits 7:6 choose interpolation 1x, 2x, 4x or 8x
// - 01h bits 5:4 choose modulation none, fs/2, fs/4, fs/8
// - 01h bit3 enables zero stuffing
// - 01h bit2 set gives independent real mixing, clear gives complex mixing
// - 01h bit1 picks negative or positive rotation in complex mode
// - two-port mode: 01h bit0 picks lock status or data clock on pin 8
// - 02h bit7 picks two's complement or straight binary input
// - 02h bit6 picks two-port or interleaved one-port input
// - 02h bit4 inverts data rate clock on pin 8 only, bit2 inverts word clock
// - 02h bit1 inverts channel select mapping
// - 02h bit0 pairs interleaved samples I then Q, or Q then I
// - 03h bit7 moves the data rate clock to the serial data output pin
// - 03h bits 1:0 set prescaler divide 1, 2, 4 or 8
// - 04h bit7 enables the PLL, default off
// - 04h bit6 selects manual charge pump current from bits 2:0
// - fine gain 8 bits and coarse gain 4 bits per channel
// - 10-bit offset per channel, plus direction bit steering to an output
// - a written byte takes effect at its last received bit
module dac_config_register_bank
(
	input  wire       i_clock,
	input  wire       i_rst_n,
	input  wire       i_reset_pin,
	input  wire       i_serial_clock,
	input  wire       i_chip_select_n,
	input  wire       i_serial_data_in,
	input  wire       i_pll_locked,
	input  wire       i_data_rate_clock,
	input  wire       i_channel_select_input,
	output reg        o_serial_data_io_out,
	output reg        o_serial_data_io_oe,
	output reg        o_serial_data_out_pin,
	output reg        o_serial_data_out_oe,
	output reg        o_data_rate_clock_out,
	output reg        o_single_port_word_clock,
	output reg        o_word_to_q,
	output reg        o_soft_reset_pulse,
	output reg        o_sleep,
	output reg        o_power_down,
	output reg        o_resistor_count_mode,
	output reg [1:0]  o_interp_rate,
	output reg [1:0]  o_mod_mode,
	output reg        o_zero_stuff,
	output reg        o_real_mix,
	output reg        o_pos_rotation,
	output reg        o_straight_binary,
	output reg        o_one_port,
	output reg        o_driver_strength,
	output reg        o_q_first,
	output reg [1:0]  o_prescale,
	output reg        o_pll_enable,
	output reg        o_cp_manual,
	output reg [2:0]  o_cp_current,
	output reg [7:0]  o_i_fine_gain,
	output reg [3:0]  o_i_coarse_gain,
	output reg [9:0]  o_i_offset,
	output reg        o_i_offset_to_comp,
	output reg [7:0]  o_q_fine_gain,
	output reg [3:0]  o_q_coarse_gain,
	output reg [9:0]  o_q_offset,
	output reg        o_q_offset_to_comp
);

	// ============================================================
	// serial port states
	localparam [3:0] ST_INSTR = 4'b0001;
	localparam [3:0] ST_WRITE = 4'b0010;
	localparam [3:0] ST_READ  = 4'b0100;
	localparam [3:0] ST_DONE  = 4'b1000;

	// ============================================================
	// pin synchronisers
	wire sclk_s;
	wire csb_s;
	wire sdi_s;
	wire hw_reset_s;
	wire lock_s;
	wire rate_s;

	pin_sync #(.INIT(1'b0)) u_sync_sclk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pin(i_serial_clock),
		.o_level(sclk_s));
	pin_sync #(.INIT(1'b1)) u_sync_csb (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pin(i_chip_select_n),
		.o_level(csb_s));
	pin_sync #(.INIT(1'b0)) u_sync_sdi (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pin(i_serial_data_in),
		.o_level(sdi_s));
	pin_sync #(.INIT(1'b0)) u_sync_rst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pin(i_reset_pin),
		.o_level(hw_reset_s));
	pin_sync #(.INIT(1'b0)) u_sync_lock (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pin(i_pll_locked),
		.o_level(lock_s));
	pin_sync #(.INIT(1'b0)) u_sync_rate (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pin(i_data_rate_clock),
		.o_level(rate_s));

	// ============================================================
	// register storage
	reg [7:0] reg_port_power_r;
	reg [7:0] reg_filter_mod_r;
	reg [7:0] reg_input_format_r;
	reg [7:0] reg_clkout_r;
	reg [7:0] reg_pll_r;
	reg [7:0] reg_i_fine_r;
	reg [7:0] reg_i_coarse_r;
	reg [7:0] reg_i_off_hi_r;
	reg [7:0] reg_i_off_lo_r;
	reg [7:0] reg_q_fine_r;
	reg [7:0] reg_q_coarse_r;
	reg [7:0] reg_q_off_hi_r;
	reg [7:0] reg_q_off_lo_r;

	// ============================================================
	// serial port state
	reg [3:0] state_r;
	reg [2:0] bit_cnt_r;
	reg [1:0] bytes_left_r;
	reg [4:0] addr_r;
	reg [7:0] in_shift_r;
	reg [7:0] rd_shift_r;
	reg       rd_bit_r;
	reg       sclk_d_r;

	wire       msb_first  = ~reg_port_power_r[`BIT_LSB_FIRST];
	wire       sclk_rise  = sclk_s & ~sclk_d_r & ~csb_s;
	wire       sclk_fall  = ~sclk_s & sclk_d_r & ~csb_s;
	wire [7:0] in_nxt     = msb_first ? {in_shift_r[6:0], sdi_s} : {sdi_s, in_shift_r[7:1]};
	wire       byte_done  = sclk_rise & (bit_cnt_r == 3'h7);
	wire [4:0] addr_inc   = addr_r + 5'h01;

	// ============================================================
	// read mux
	function [7:0] read_value;
		input [4:0] a;
		begin
			case (a)
				`ADDR_PORT_POWER:
				begin
					read_value = reg_port_power_r;
					read_value[`BIT_PLL_LOCK] = lock_s & reg_pll_r[`BIT_PLL_ENABLE];
				end
				`ADDR_FILTER_MOD:      read_value = reg_filter_mod_r;
				`ADDR_INPUT_FORMAT:    read_value = reg_input_format_r;
				`ADDR_CLKOUT_PRESCALE: read_value = reg_clkout_r;
				`ADDR_PLL_CONTROL:     read_value = reg_pll_r;
				`ADDR_I_FINE_GAIN:     read_value = reg_i_fine_r;
				`ADDR_I_COARSE_GAIN:   read_value = reg_i_coarse_r;
				`ADDR_I_OFFSET_HIGH:   read_value = reg_i_off_hi_r;
				`ADDR_I_OFFSET_LOW:    read_value = reg_i_off_lo_r;
				`ADDR_Q_FINE_GAIN:     read_value = reg_q_fine_r;
				`ADDR_Q_COARSE_GAIN:   read_value = reg_q_coarse_r;
				`ADDR_Q_OFFSET_HIGH:   read_value = reg_q_off_hi_r;
				`ADDR_Q_OFFSET_LOW:    read_value = reg_q_off_lo_r;
				default:               read_value = 8'h00;
			endcase
		end
	endfunction

	// ============================================================
	// serial port and register writes
	wire       wr_strobe = byte_done & (state_r == ST_WRITE);
	wire       soft_rst  = wr_strobe & (addr_r == `ADDR_PORT_POWER) & in_nxt[`BIT_SOFT_RESET];

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r      <= ST_INSTR;
			bit_cnt_r    <= 3'h0;
			bytes_left_r <= 2'h0;
			addr_r       <= 5'h00;
			in_shift_r   <= 8'h00;
			rd_shift_r   <= 8'h00;
			rd_bit_r     <= 1'b0;
			sclk_d_r     <= 1'b0;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			if (csb_s)
			begin
				// chip select high aborts any partial byte
				state_r   <= ST_INSTR;
				bit_cnt_r <= 3'h0;
			end
			else if (sclk_rise)
			begin
				in_shift_r <= in_nxt;
				bit_cnt_r  <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7)
				begin
					case (state_r)
						ST_INSTR:
						begin
							bytes_left_r <= in_nxt[`INSTR_COUNT_HI:`INSTR_COUNT_LO];
							addr_r       <= in_nxt[4:0];
							if (in_nxt[`INSTR_READ_BIT])
							begin
								state_r    <= ST_READ;
								rd_shift_r <= read_value(in_nxt[4:0]);
							end
							else
								state_r <= ST_WRITE;
						end
						ST_WRITE:
						begin
							addr_r       <= addr_inc;
							bytes_left_r <= bytes_left_r - 2'h1;
							if (bytes_left_r == 2'h0)
								state_r <= ST_DONE;
						end
						ST_READ:
						begin
							addr_r       <= addr_inc;
							bytes_left_r <= bytes_left_r - 2'h1;
							rd_shift_r   <= read_value(addr_inc);
							if (bytes_left_r == 2'h0)
								state_r <= ST_DONE;
						end
						default:
							state_r <= ST_DONE;
					endcase
				end
			end
			else if (sclk_fall && state_r == ST_READ)
			begin
				// read data leaves on the falling edge
				rd_bit_r   <= msb_first ? rd_shift_r[7] : rd_shift_r[0];
				rd_shift_r <= msb_first ? {rd_shift_r[6:0], 1'b0} : {1'b0, rd_shift_r[7:1]};
			end
		end
	end

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			reg_port_power_r   <= `RST_PORT_POWER;
			reg_filter_mod_r   <= `RST_FILTER_MOD;
			reg_input_format_r <= `RST_INPUT_FORMAT;
			reg_clkout_r       <= `RST_CLKOUT_PRESCALE;
			reg_pll_r          <= `RST_PLL_CONTROL;
			reg_i_fine_r       <= `RST_GAIN_OFFSET;
			reg_i_coarse_r     <= `RST_GAIN_OFFSET;
			reg_i_off_hi_r     <= `RST_GAIN_OFFSET;
			reg_i_off_lo_r     <= `RST_GAIN_OFFSET;
			reg_q_fine_r       <= `RST_GAIN_OFFSET;
			reg_q_coarse_r     <= `RST_GAIN_OFFSET;
			reg_q_off_hi_r     <= `RST_GAIN_OFFSET;
			reg_q_off_lo_r     <= `RST_GAIN_OFFSET;
			o_soft_reset_pulse <= 1'b0;
		end
		else
		begin
			o_soft_reset_pulse <= soft_rst & ~hw_reset_s;
			if (hw_reset_s)
			begin
				reg_port_power_r <= `RST_PORT_POWER;
			end
			else if (wr_strobe && addr_r == `ADDR_PORT_POWER)
				reg_port_power_r <= in_nxt & `MASK_PORT_POWER;
			if (hw_reset_s || soft_rst)
			begin
				// soft reset spares 00h
				reg_filter_mod_r   <= `RST_FILTER_MOD;
				reg_input_format_r <= `RST_INPUT_FORMAT;
				reg_clkout_r       <= `RST_CLKOUT_PRESCALE;
				reg_pll_r          <= `RST_PLL_CONTROL;
				reg_i_fine_r       <= `RST_GAIN_OFFSET;
				reg_i_coarse_r     <= `RST_GAIN_OFFSET;
				reg_i_off_hi_r     <= `RST_GAIN_OFFSET;
				reg_i_off_lo_r     <= `RST_GAIN_OFFSET;
				reg_q_fine_r       <= `RST_GAIN_OFFSET;
				reg_q_coarse_r     <= `RST_GAIN_OFFSET;
				reg_q_off_hi_r     <= `RST_GAIN_OFFSET;
				reg_q_off_lo_r     <= `RST_GAIN_OFFSET;
			end
			else if (wr_strobe)
			begin
				case (addr_r)
					`ADDR_FILTER_MOD:      reg_filter_mod_r   <= in_nxt & `MASK_FILTER_MOD;
					`ADDR_INPUT_FORMAT:    reg_input_format_r <= in_nxt & `MASK_INPUT_FORMAT;
					`ADDR_CLKOUT_PRESCALE: reg_clkout_r       <= in_nxt & `MASK_CLKOUT_PRESCALE;
					`ADDR_PLL_CONTROL:     reg_pll_r          <= in_nxt & `MASK_PLL_CONTROL;
					`ADDR_I_FINE_GAIN:     reg_i_fine_r       <= in_nxt & `MASK_FULL;
					`ADDR_I_COARSE_GAIN:   reg_i_coarse_r     <= in_nxt & `MASK_COARSE_GAIN;
					`ADDR_I_OFFSET_HIGH:   reg_i_off_hi_r     <= in_nxt & `MASK_FULL;
					`ADDR_I_OFFSET_LOW:    reg_i_off_lo_r     <= in_nxt & `MASK_OFFSET_LOW;
					`ADDR_Q_FINE_GAIN:     reg_q_fine_r       <= in_nxt & `MASK_FULL;
					`ADDR_Q_COARSE_GAIN:   reg_q_coarse_r     <= in_nxt & `MASK_COARSE_GAIN;
					`ADDR_Q_OFFSET_HIGH:   reg_q_off_hi_r     <= in_nxt & `MASK_FULL;
					`ADDR_Q_OFFSET_LOW:    reg_q_off_lo_r     <= in_nxt & `MASK_OFFSET_LOW;
					default:               reg_q_off_lo_r     <= reg_q_off_lo_r;
				endcase
			end
		end
	end

	// ============================================================
	// registered outputs
	wire read_active = ~csb_s & (state_r == ST_READ);
	wire bidir       = reg_port_power_r[`BIT_SDIO_BIDIR];
	wire clk_on_sdo  = reg_clkout_r[`BIT_CLK_ON_SDO];
	wire rate_inv    = rate_s ^ reg_input_format_r[`BIT_RATE_CLK_INVERT];
	wire one_port    = reg_input_format_r[`BIT_ONE_PORT];

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_serial_data_io_out     <= 1'b0;
			o_serial_data_io_oe      <= 1'b0;
			o_serial_data_out_pin    <= 1'b0;
			o_serial_data_out_oe     <= 1'b0;
			o_data_rate_clock_out    <= 1'b0;
			o_single_port_word_clock <= 1'b0;
			o_word_to_q              <= 1'b0;
		end
		else
		begin
			o_serial_data_io_out <= rd_bit_r;
			o_serial_data_io_oe  <= read_active & bidir;
			if (clk_on_sdo)
			begin
				// the invert bit serves pin 8 only; the moved clock leaves as is
				o_serial_data_out_pin <= rate_s;
				o_serial_data_out_oe  <= 1'b1;
			end
			else
			begin
				o_serial_data_out_pin <= rd_bit_r;
				o_serial_data_out_oe  <= read_active & ~bidir;
			end
			if (!one_port && !reg_filter_mod_r[`BIT_PIN8_RATE_CLK])
				o_data_rate_clock_out <= lock_s;
			else
				o_data_rate_clock_out <= rate_inv & ~clk_on_sdo;
			o_single_port_word_clock <= rate_s ^ reg_input_format_r[`BIT_WORDCLK_INVERT];
			o_word_to_q <= i_channel_select_input ^ reg_input_format_r[`BIT_CHSEL_INVERT];
		end
	end

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_sleep               <= 1'b0;
			o_power_down          <= 1'b0;
			o_resistor_count_mode <= 1'b0;
			o_interp_rate         <= 2'h0;
			o_mod_mode            <= 2'h0;
			o_zero_stuff          <= 1'b0;
			o_real_mix            <= 1'b1;
			o_pos_rotation        <= 1'b0;
			o_straight_binary     <= 1'b0;
			o_one_port            <= 1'b0;
			o_driver_strength     <= 1'b0;
			o_q_first             <= 1'b0;
			o_prescale            <= 2'h0;
			o_pll_enable          <= 1'b0;
			o_cp_manual           <= 1'b0;
			o_cp_current          <= 3'h0;
			o_i_fine_gain         <= 8'h00;
			o_i_coarse_gain       <= 4'h0;
			o_i_offset            <= 10'h000;
			o_i_offset_to_comp    <= 1'b0;
			o_q_fine_gain         <= 8'h00;
			o_q_coarse_gain       <= 4'h0;
			o_q_offset            <= 10'h000;
			o_q_offset_to_comp    <= 1'b0;
		end
		else
		begin
			o_sleep               <= reg_port_power_r[`BIT_SLEEP];
			o_power_down          <= reg_port_power_r[`BIT_POWER_DOWN];
			o_resistor_count_mode <= reg_port_power_r[`BIT_ONE_RESISTOR];
			o_interp_rate         <= reg_filter_mod_r[7:6];
			o_mod_mode            <= reg_filter_mod_r[5:4];
			o_zero_stuff          <= reg_filter_mod_r[`BIT_ZERO_STUFF];
			o_real_mix            <= reg_filter_mod_r[`BIT_REAL_MIX];
			o_pos_rotation        <= reg_filter_mod_r[`BIT_POS_ROTATION];
			o_straight_binary     <= reg_input_format_r[`BIT_STRAIGHT_BINARY];
			o_one_port            <= one_port;
			o_driver_strength     <= reg_input_format_r[`BIT_DRIVER_STRENGTH];
			o_q_first             <= reg_input_format_r[`BIT_Q_FIRST];
			o_prescale            <= reg_clkout_r[1:0];
			o_pll_enable          <= reg_pll_r[`BIT_PLL_ENABLE];
			o_cp_manual           <= reg_pll_r[`BIT_CP_MANUAL];
			o_cp_current          <= reg_pll_r[2:0];
			o_i_fine_gain         <= reg_i_fine_r;
			o_i_coarse_gain       <= reg_i_coarse_r[3:0];
			o_i_offset            <= {reg_i_off_hi_r, reg_i_off_lo_r[1:0]};
			o_i_offset_to_comp    <= reg_i_off_lo_r[`BIT_OFFSET_TO_COMP];
			o_q_fine_gain         <= reg_q_fine_r;
			o_q_coarse_gain       <= reg_q_coarse_r[3:0];
			o_q_offset            <= {reg_q_off_hi_r, reg_q_off_lo_r[1:0]};
			o_q_offset_to_comp    <= reg_q_off_lo_r[`BIT_OFFSET_TO_COMP];
		end
	end

endmodule // dac_config_register_bank

// ### verification/dac_config_register_bank_properties.sv
// port-level checks for the configuration register bank
`timescale 1ns/1ps

module dac_config_register_bank_properties
(
	input wire       i_clock,
	input wire       i_rst_n,
	input wire       i_reset_pin,
	input wire       i_chip_select_n,
	input wire       i_channel_select_input,
	input wire       o_serial_data_io_oe,
	input wire       o_serial_data_out_oe,
	input wire       o_serial_data_out_pin,
	input wire       o_data_rate_clock_out,
	input wire       o_word_to_q,
	input wire       o_soft_reset_pulse,
	input wire       o_sleep,
	input wire       o_real_mix,
	input wire [1:0] o_interp_rate,
	input wire [7:0] o_i_fine_gain
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	// ============================================================
	// serial pins
	chk_io_released: assert property (i_chip_select_n [*8] |-> !o_serial_data_io_oe)
		else $error("data io pin driven outside a frame");
	chk_io_in_frame: assert property ($rose(o_serial_data_io_oe) |-> !i_chip_select_n)
		else $error("data io pin enabled without chip select");
	// margin of 8 covers the chip select synchroniser
	chk_pin8_parked: assert property ((i_chip_select_n && o_serial_data_out_oe) [*8] |-> !o_data_rate_clock_out)
		else $error("data clock pin active while clock is on serial out");
	chk_sdo_clock: assert property ((i_chip_select_n && o_serial_data_out_oe) [*8] |-> ##[1:9] !$stable(o_serial_data_out_pin))
		else $error("serial out pin carries no clock");
	chk_word_select: assert property ($changed(i_channel_select_input) |=> $changed(o_word_to_q))
		else $error("word routing ignores channel select");

	// ============================================================
	// resets and register updates
	chk_soft_single: assert property (o_soft_reset_pulse |=> !o_soft_reset_pulse)
		else $error("soft reset pulse longer than one cycle");
	chk_soft_clears: assert property (o_soft_reset_pulse |-> ##[0:2] (o_real_mix && o_i_fine_gain == 8'h00 && o_interp_rate == 2'h0))
		else $error("soft reset left fields set");
	chk_pin_defaults: assert property (i_reset_pin [*8] |-> (o_real_mix && !o_sleep && o_i_fine_gain == 8'h00 && o_interp_rate == 2'h0))
		else $error("reset pin did not restore defaults");
	chk_fields_quiet: assert property ((i_chip_select_n && !i_reset_pin) [*8] |=> $stable(o_i_fine_gain) && $stable(o_interp_rate) && $stable(o_sleep))
		else $error("field changed outside a write");

	cover property (o_soft_reset_pulse);
	cover property ($rose(o_serial_data_io_oe));
	cover property (i_reset_pin [*8]);
	cover property ((i_chip_select_n && o_serial_data_out_oe) [*8]);
endmodule // dac_config_register_bank_properties

bind dac_config_register_bank dac_config_register_bank_properties i_dac_config_register_bank_properties
(
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reset_pin(i_reset_pin), .i_chip_select_n(i_chip_select_n),
	.i_channel_select_input(i_channel_select_input), .o_serial_data_io_oe(o_serial_data_io_oe),
	.o_serial_data_out_oe(o_serial_data_out_oe), .o_serial_data_out_pin(o_serial_data_out_pin),
	.o_data_rate_clock_out(o_data_rate_clock_out), .o_word_to_q(o_word_to_q),
	.o_soft_reset_pulse(o_soft_reset_pulse), .o_sleep(o_sleep), .o_real_mix(o_real_mix),
	.o_interp_rate(o_interp_rate), .o_i_fine_gain(o_i_fine_gain)
);

// ### verification/host_serial_model.sv
// host controller model for the serial control port
`timescale 1ns/1ps

module host_serial_model
(
	input  wire logic i_clock,
	input  wire logic i_sdo,
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_sdi
);
	logic lsb_first = 1'b0;

	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_sdi = 1'b0;
	end

	task automatic tick(input int c);
		repeat (c) @(posedge i_clock);
		#10;
	endtask

	// ============================================================
	// one frame; a nonzero cut raises chip select after that many bits
	task automatic xfer(input logic [7:0] instr, input logic [31:0] wdata, input int cut, output logic [31:0] rdata);
		int n;
		int k;
		int j;
		n = cut ? cut : 8 * (int'(instr[6:5]) + 2);
		rdata = 32'h0;
		o_cs_n = 1'b0;
		tick(8);
		for (int b = 0; b < n; b++)
		begin
			k = lsb_first ? b % 8 : 7 - b % 8;
			j = b / 8 - 1;
			o_sclk = 1'b0;
			// released during reads: keep it wandering so a stale level cannot pass
			o_sdi = (b < 8) ? instr[k] : (instr[7] ? ~o_sdi : wdata[j * 8 + k]);
			tick(8);
			o_sclk = 1'b1;
			if (b >= 8)
				rdata[j * 8 + k] = i_sdo;
			tick(8);
		end
		o_sclk = 1'b0;
		tick(8);
		o_cs_n = 1'b1;
		tick(8);
	endtask
endmodule // host_serial_model

// ### verification/test_dac_config_register_bank.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps

module test_dac_config_register_bank;
	logic        clock, rst_n, reset_pin, locked, drc, chsel, bidir, sclk, cs_n, sdi;
	wire         io_out, io_oe, sdo_pin, sdo_oe, pin8, word_clk, to_q, sleep, pdown, one_r, zstuff, rmix, prot;
	wire         sbin, oport, dstr, qfirst, pll_en, cp_man, icomp, qcomp;
	wire  [1:0]  interp, modm, presc;
	wire  [2:0]  cp_cur;
	wire  [3:0]  icoarse, qcoarse;
	wire  [7:0]  ifine, qfine;
	wire  [9:0]  ioff, qoff;
	int          fail_count, checks;
	logic [31:0] r;
	// the shared data pin as the wire sees it; an undriven line reads inverted
	wire         sdio = io_oe ? io_out : sdi;
	wire         line = bidir ? (io_oe ? io_out : ~io_out) : (sdo_oe ? sdo_pin : ~sdo_pin);

	dac_config_register_bank i_dac_config_register_bank
	(
		.i_clock(clock), .i_rst_n(rst_n), .i_reset_pin(reset_pin), .i_serial_clock(sclk), .i_chip_select_n(cs_n),
		.i_serial_data_in(sdio), .i_pll_locked(locked), .i_data_rate_clock(drc), .i_channel_select_input(chsel),
		.o_serial_data_io_out(io_out), .o_serial_data_io_oe(io_oe), .o_serial_data_out_pin(sdo_pin),
		.o_serial_data_out_oe(sdo_oe), .o_data_rate_clock_out(pin8), .o_single_port_word_clock(word_clk),
		.o_word_to_q(to_q), .o_soft_reset_pulse(), .o_sleep(sleep), .o_power_down(pdown),
		.o_resistor_count_mode(one_r), .o_interp_rate(interp), .o_mod_mode(modm), .o_zero_stuff(zstuff),
		.o_real_mix(rmix), .o_pos_rotation(prot), .o_straight_binary(sbin), .o_one_port(oport),
		.o_driver_strength(dstr), .o_q_first(qfirst), .o_prescale(presc), .o_pll_enable(pll_en), .o_cp_manual(cp_man),
		.o_cp_current(cp_cur), .o_i_fine_gain(ifine), .o_i_coarse_gain(icoarse), .o_i_offset(ioff),
		.o_i_offset_to_comp(icomp), .o_q_fine_gain(qfine), .o_q_coarse_gain(qcoarse), .o_q_offset(qoff),
		.o_q_offset_to_comp(qcomp)
	);

	host_serial_model i_host_serial_model (.i_clock(clock), .i_sdo(line), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

	// ============================================================
	// helpers
	task automatic tick(input int c);
		repeat (c) @(posedge clock);
		#10;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input int n, input logic [31:0] d);
		i_host_serial_model.xfer({1'b0, 2'(n - 1), a}, d, 0, r);
	endtask

	task automatic rd(input logic [4:0] a, input int n);
		i_host_serial_model.xfer({1'b1, 2'(n - 1), a}, 32'h0, 0, r);
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ============================================================
	// scenarios
	task automatic t_defaults;
		rd(5'h00, 4);
		chk(r, 32'h00000400);
		rd(5'h04, 4);
		chk(r, 32'h0);
		rd(5'h08, 4);
		chk(r, 32'h0);
		rd(5'h0c, 2);
		chk(r, 32'h0);
		chk({rmix, interp, pll_en, cp_man}, 32'h10);
	endtask

	task automatic t_modes;
		logic [1:0] k;
		logic [2:0] c;
		for (int i = 0; i < 4; i++)
		begin
			k = 2'(i);
			wr(5'h01, 3, {6'h1f, k, k[0], k[1], k[1], 4'h8, k[0], k, k, 4'ha});
			chk({interp, modm, zstuff, rmix, prot, presc, sbin, oport, dstr, qfirst}, {k, k, 3'h5, k, k[0], k[1], k[1], k[0]});
			rd(5'h01, 3);
			chk(r, {14'h0, k, k[0], k[1], k[1], 4'h8, k[0], k, k, 4'ha});
		end
		for (int i = 0; i < 5; i++)
		begin
			c = (i == 4) ? 3'h7 : 3'(i);
			wr(5'h04, 1, {2'h1, 3'h7, c});
			chk({cp_man, cp_cur}, {1'b1, c});
			rd(5'h04, 1);
			chk(r, {2'h1, 3'h0, c});
		end
	endtask

	task automatic t_gain;
		wr(5'h05, 4, 32'hff3cffa5);
		chk({ifine, icoarse, ioff, icomp}, {8'ha5, 4'hf, 10'h0f3, 1'b1});
		rd(5'h05, 4);
		chk(r, 32'h833c0fa5);
		wr(5'h09, 4, 32'h7ec3f65a);
		chk({qfine, qcoarse, qoff, qcomp}, {8'h5a, 4'h6, 10'h30e, 1'b0});
		rd(5'h09, 4);
		chk(r, 32'h02c3065a);
		i_host_serial_model.xfer(8'h05, 32'h11, 12, r);
		rd(5'h05, 1);
		chk(r, 32'ha5);
	endtask

	task automatic t_pll;
		locked = 1'b1;
		wr(5'h04, 1, 32'h0);
		rd(5'h00, 1);
		chk(r, 32'h0);
		wr(5'h04, 1, 32'h80);
		rd(5'h00, 1);
		chk({pll_en, r[7:0]}, 32'h102);
		locked = 1'b0;
		rd(5'h00, 1);
		chk(r, 32'h0);
	endtask

	task automatic t_soft;
		wr(5'h00, 1, 32'h3c);
		chk({sleep, pdown, one_r, rmix, pll_en, ifine, qoff}, {4'hf, 19'h0});
		rd(5'h00, 4);
		chk(r, 32'h0000041c);
		wr(5'h00, 1, 32'h0);
		wr(5'h04, 1, 32'h80);
	endtask

	task automatic t_bidir;
		wr(5'h00, 1, 32'hc0);
		bidir = 1'b1;
		i_host_serial_model.lsb_first = 1'b1;
		wr(5'h01, 1, 32'h96);
		rd(5'h01, 1);
		chk({interp, r[7:0]}, 32'h296);
		wr(5'h00, 1, 32'h0);
		bidir = 1'b0;
		i_host_serial_model.lsb_first = 1'b0;
		rd(5'h01, 1);
		chk(r, 32'h96);
	endtask

	task automatic t_pins;
		wr(5'h02, 1, 32'h16);
		chsel = 1'b1;
		tick(2);
		chk(to_q, 32'h0);
		chsel = 1'b0;
		tick(2);
		chk(to_q, 32'h1);
		@(drc);
		tick(7);
		chk(word_clk, !drc);
		locked = 1'b1;
		tick(8);
		chk(pin8, 32'h1);
		locked = 1'b0;
		tick(8);
		chk(pin8, 32'h0);
		wr(5'h01, 1, 32'h97);
		@(drc);
		tick(7);
		chk(pin8, !drc);
		wr(5'h03, 1, 32'h80);
		@(drc);
		tick(7);
		chk({sdo_oe, sdo_pin, pin8}, {1'b1, drc, 1'b0});
		wr(5'h03, 1, 32'h0);
	endtask

	task automatic t_hw;
		wr(5'h00, 1, 32'h10);
		reset_pin = 1'b1;
		tick(12);
		chk({sleep, rmix, interp, pll_en}, 32'h8);
		reset_pin = 1'b0;
		tick(6);
		rd(5'h00, 4);
		chk(r, 32'h00000400);
	endtask

	// ============================================================
	// clock, data rate clock, sequence and watchdog
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial
	begin
		drc = 1'b0;
		forever
		begin
			repeat (8) @(posedge clock);
			#10 drc = ~drc;
		end
	end

	initial
	begin
		{rst_n, reset_pin, locked, chsel, bidir} = 5'h0;
		fail_count = 0;
		checks = 0;
		tick(8);
		rst_n = 1'b1;
		tick(8);
		t_defaults;
		t_modes;
		t_gain;
		t_pll;
		t_soft;
		t_bidir;
		t_pins;
		t_hw;
		summarize;
	end

	initial
	begin
		#4000000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		summarize;
	end
endmodule // test_dac_config_register_bank
